// [lgc_global_control.v]
/*
 Global control and status of an eight-channel line interface unit:
 loss-of-signal zero counting, in-circuit-test tristate, master clock
 rate select and the channel 0 interrupt indicator.
 Assumes receive data and channel 0 events are synchronous to clock,
 one sample per cycle qualified by rx_valid.
*/
// The Avalon-MM register port was left to the implementer.
// Function
// - Extended loss bit set: declare loss after 4096 consecutive zeros.
// - Extended loss bit clear: declare loss after 175 consecutive zeros.
// - Test bit, default 0, tristates the eight line outputs (line_out_oe all low) while set.
// - Register three is reserved, default zero, no effect on behaviour.
// - Four-bit clock select in register four, reset 0001.
// - Code 0000 is 2.048MHz, 0001 1.544MHz, 0010-0111 reserved.
// - Codes 1000-1101 select 4.096, 3.088, 8.192, 6.176, 16.384, 12.352MHz.
// - Code 1110 is 2.048MHz, code 1111 1.544MHz.
// - Channel 0 interrupt bit reads 1 since last read, clears on read.
`timescale 1ns/1ps
`default_nettype none
`include "lgc_map.vh"

module lgc_global_control
(
    // Clock and reset
    input wire clock,
    input wire reset_n,
    // Avalon-MM slave
    input wire [13:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    output reg [31:0] avs_readdata,
    output reg avs_waitrequest,
    // Receive line samples, one bit per channel
    input wire [7:0] rx_data,
    input wire [7:0] rx_valid,
    // Channel 0 interrupt event
    input wire channel0_event,
    // Line outputs from the channel logic
    input wire [7:0] line_out_in,
    // Outputs
    output reg [7:0] line_out,
    output reg [7:0] line_out_oe,
    output reg [7:0] receive_loss_of_signal,
    output reg [3:0] master_clock_rate_select,
    output reg [14:0] master_clock_khz,
    output reg master_clock_reserved,
    output reg irq
);

    // ==========================================================
    // Rate decode, used for the kHz status output and the reserved flag
    function [14:0] lgc_rate_khz;
        input [3:0] sel;
        begin
            case (sel)
                `LGC_CS_2048A: lgc_rate_khz = `LGC_KHZ_2048;
                `LGC_CS_1544A: lgc_rate_khz = `LGC_KHZ_1544;
                `LGC_CS_4096: lgc_rate_khz = `LGC_KHZ_4096;
                `LGC_CS_3088: lgc_rate_khz = `LGC_KHZ_3088;
                `LGC_CS_8192: lgc_rate_khz = `LGC_KHZ_8192;
                `LGC_CS_6176: lgc_rate_khz = `LGC_KHZ_6176;
                `LGC_CS_16384: lgc_rate_khz = `LGC_KHZ_16384;
                `LGC_CS_12352: lgc_rate_khz = `LGC_KHZ_12352;
                `LGC_CS_2048B: lgc_rate_khz = `LGC_KHZ_2048;
                `LGC_CS_1544B: lgc_rate_khz = `LGC_KHZ_1544;
                default: lgc_rate_khz = `LGC_KHZ_NONE;
            endcase
        end
    endfunction

    // ==========================================================
    // Register decode, shared by writes and clear-on-read strobes
    localparam HIT_ONE = 0;
    localparam HIT_TWO = 1;
    localparam HIT_THREE = 2;
    localparam HIT_RATE = 3;
    localparam HIT_INT = 4;
    localparam HIT_EVT = 5;
    localparam HIT_MASK = 6;
    function [6:0] lgc_hit;
        input [11:0] index;
        begin
            lgc_hit = 7'h00;
            case (index)
                `LGC_IDX_CTRL_ONE: lgc_hit[HIT_ONE] = 1'b1;
                `LGC_IDX_CTRL_TWO: lgc_hit[HIT_TWO] = 1'b1;
                `LGC_IDX_CTRL_THREE: lgc_hit[HIT_THREE] = 1'b1;
                `LGC_IDX_CLK_RATE: lgc_hit[HIT_RATE] = 1'b1;
                `LGC_IDX_INT_SUM: lgc_hit[HIT_INT] = 1'b1;
                `LGC_IDX_EVT_STATUS: lgc_hit[HIT_EVT] = 1'b1;
                `LGC_IDX_EVT_MASK: lgc_hit[HIT_MASK] = 1'b1;
                default: lgc_hit = 7'h00;
            endcase
        end
    endfunction

    // ==========================================================
    // Registers
    reg [7:0] ctrl_one_q;
    reg [7:0] ctrl_two_q;
    reg [7:0] ctrl_three_q;
    reg [7:0] clk_rate_q;
    reg ch0_int_q;
    reg [7:0] evt_status_q;
    reg [7:0] evt_mask_q;
    reg ack_q;

    wire [11:0] idx = avs_address[13:2];
    wire ext_los = ctrl_one_q[`LGC_BIT_EXTENDED_LOSS_ENABLE];
    wire in_circuit_test_tristate = ctrl_one_q[`LGC_BIT_ICT];
    wire wr_lo = avs_write && avs_byteenable[0] && !ack_q;
    wire rd_go = avs_read && !ack_q;
    wire [6:0] hit = lgc_hit(idx);
    // Threshold is the count reached on the declaring zero
    wire [`LGC_CNT_W-1:0] los_limit = ext_los ? `LGC_LOS_ZEROS_EXT
        : `LGC_LOS_ZEROS_STD;

    // ==========================================================
    // Per-channel consecutive zero counters
    wire [7:0] los_rise;
    wire [7:0] los_d;
    genvar ch;
    generate
        for (ch = 0; ch < 8; ch = ch + 1)
        begin : g_los
            reg [`LGC_CNT_W-1:0] zero_cnt_q;
            wire [`LGC_CNT_W-1:0] zero_inc = zero_cnt_q + 1'b1;
            wire zero_in = rx_valid[ch] && !rx_data[ch];
            wire one_in = rx_valid[ch] && rx_data[ch];
            wire at_limit = zero_in && (zero_inc >= los_limit);
            // Saturate at the limit so a long outage never wraps
            always @(posedge clock)
            begin
                if (!reset_n)
                    zero_cnt_q <= {`LGC_CNT_W{1'b0}};
                else if (one_in)
                    zero_cnt_q <= {`LGC_CNT_W{1'b0}};
                else if (at_limit)
                    zero_cnt_q <= los_limit;
                else if (zero_in)
                    zero_cnt_q <= zero_inc;
            end
            // Level drops on a one, rises on the declaring zero
            assign los_d[ch] = one_in ? 1'b0
                : (at_limit | receive_loss_of_signal[ch]);
            assign los_rise[ch] = at_limit && !receive_loss_of_signal[ch];
        end
    endgenerate

    // One register for all channels keeps a single driver per output
    always @(posedge clock)
    begin
        if (!reset_n)
            receive_loss_of_signal <= 8'h00;
        else
            receive_loss_of_signal <= los_d;
    end

    // ==========================================================
    // Read mux
    reg [7:0] rd_d;
    always @*
    begin
        rd_d = 8'h00;
        case (idx)
            `LGC_IDX_CTRL_ONE: rd_d = ctrl_one_q;
            `LGC_IDX_CTRL_TWO: rd_d = ctrl_two_q;
            `LGC_IDX_CTRL_THREE: rd_d = ctrl_three_q;
            `LGC_IDX_CLK_RATE: rd_d = clk_rate_q;
            `LGC_IDX_INT_SUM: rd_d = {7'h00, ch0_int_q};
            `LGC_IDX_LOS_STATUS: rd_d = receive_loss_of_signal;
            `LGC_IDX_EVT_STATUS: rd_d = evt_status_q;
            `LGC_IDX_EVT_MASK: rd_d = evt_mask_q;
            default: rd_d = 8'h00;
        endcase
    end

    // ==========================================================
    // Bus slave: one wait cycle, answer on the second edge
    // A request is taken only while no answer is pending, so a request
    // held over the answer edge is never counted twice
    always @(posedge clock)
    begin
        if (!reset_n)
        begin
            ack_q <= 1'b0;
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h0000_0000;
        end
        else
        begin
            ack_q <= (avs_read || avs_write) && !ack_q;
            avs_waitrequest <= !((avs_read || avs_write) && !ack_q);
            if (rd_go)
                avs_readdata <= {24'h00_0000, rd_d};
        end
    end

    // ==========================================================
    // Control registers, each written only through its own hit
    always @(posedge clock)
    begin
        if (!reset_n)
            ctrl_one_q <= `LGC_RST_CTRL_ONE;
        else if (wr_lo && hit[HIT_ONE])
            ctrl_one_q <= avs_writedata[7:0];
    end

    always @(posedge clock)
    begin
        if (!reset_n)
            ctrl_two_q <= `LGC_RST_CTRL_TWO;
        else if (wr_lo && hit[HIT_TWO])
            ctrl_two_q <= avs_writedata[7:0];
    end

    // Stored for readback only; nothing decodes it
    always @(posedge clock)
    begin
        if (!reset_n)
            ctrl_three_q <= `LGC_RST_CTRL_THREE;
        else if (wr_lo && hit[HIT_THREE])
            ctrl_three_q <= avs_writedata[7:0];
    end

    // Upper nibble is reserved: it reads zero and ignores writes
    always @(posedge clock)
    begin
        if (!reset_n)
            clk_rate_q <= `LGC_RST_CLK_RATE;
        else if (wr_lo && hit[HIT_RATE])
            clk_rate_q <= {4'h0, avs_writedata[`LGC_CLKSEL_MSB:0]};
    end

    always @(posedge clock)
    begin
        if (!reset_n)
            evt_mask_q <= `LGC_RST_MASK;
        else if (wr_lo && hit[HIT_MASK])
            evt_mask_q <= avs_writedata[7:0];
    end

    // ==========================================================
    // Sticky flags: set wins over clear-on-read
    wire rd_int = rd_go && hit[HIT_INT];
    wire rd_evt = rd_go && hit[HIT_EVT];
    wire [7:0] evt_set = {6'h00, |los_rise, channel0_event};
    wire [7:0] evt_keep = evt_status_q & {8{~rd_evt}};
    wire [7:0] evt_status_d = evt_set | evt_keep;
    always @(posedge clock)
    begin
        if (!reset_n)
            ch0_int_q <= 1'b0;
        else
            ch0_int_q <= channel0_event | (ch0_int_q & ~rd_int);
    end

    // Level output follows the next status so it never lags a new event
    always @(posedge clock)
    begin
        if (!reset_n)
        begin
            evt_status_q <= 8'h00;
            irq <= 1'b0;
        end
        else
        begin
            evt_status_q <= evt_status_d;
            irq <= |(evt_status_d & evt_mask_q);
        end
    end

    // ==========================================================
    // Line outputs: enables drop together while the test bit is set
    always @(posedge clock)
    begin
        if (!reset_n)
        begin
            line_out <= 8'h00;
            line_out_oe <= 8'h00;
        end
        else
        begin
            line_out <= line_out_in;
            line_out_oe <= in_circuit_test_tristate ? 8'h00 : 8'hFF;
        end
    end

    // ==========================================================
    // Clock rate status; the rate decode is shared with the reserved flag
    wire [14:0] rate_d = lgc_rate_khz(clk_rate_q[`LGC_CLKSEL_MSB:0]);
    always @(posedge clock)
    begin
        if (!reset_n)
        begin
            master_clock_rate_select <= `LGC_CS_1544A;
            master_clock_khz <= `LGC_KHZ_1544;
            master_clock_reserved <= 1'b0;
        end
        else
        begin
            master_clock_rate_select <= clk_rate_q[`LGC_CLKSEL_MSB:0];
            master_clock_khz <= rate_d;
            master_clock_reserved <= (rate_d == `LGC_KHZ_NONE);
        end
    end

endmodule
`default_nettype wire

// [lgc_map.vh]
/*
 Register map, field positions, reset values and timing counts of the
 global line control block. Assumes an 8-bit register file reached over
 Avalon-MM with a 32-bit data path, one word per register.
*/
`ifndef LGC_MAP_VH
`define LGC_MAP_VH

// ==========================================================
// Register indices (byte address is four times the index)
`define LGC_IDX_CTRL_ONE 12'hFE1
`define LGC_IDX_CTRL_TWO 12'hFE2
`define LGC_IDX_CTRL_THREE 12'hFE4
`define LGC_IDX_CLK_RATE 12'hFE9
`define LGC_IDX_INT_SUM 12'hFEA
`define LGC_IDX_LOS_STATUS 12'hFF8
`define LGC_IDX_EVT_STATUS 12'hFF9
`define LGC_IDX_EVT_MASK 12'hFFA

// ==========================================================
// Field positions and reset values
`define LGC_BIT_ICT 0
`define LGC_BIT_EXTENDED_LOSS_ENABLE 1
`define LGC_BIT_CH0_INT 0
`define LGC_CLKSEL_MSB 3
`define LGC_RST_CTRL_ONE 8'h00
`define LGC_RST_CTRL_TWO 8'h00
`define LGC_RST_CTRL_THREE 8'h00
`define LGC_RST_CLK_RATE 8'h01
`define LGC_RST_MASK 8'h00

// ==========================================================
// Clock select codes and rates in kHz
`define LGC_CS_2048A 4'h0
`define LGC_CS_1544A 4'h1
`define LGC_CS_4096 4'h8
`define LGC_CS_3088 4'h9
`define LGC_CS_8192 4'hA
`define LGC_CS_6176 4'hB
`define LGC_CS_16384 4'hC
`define LGC_CS_12352 4'hD
`define LGC_CS_2048B 4'hE
`define LGC_CS_1544B 4'hF
`define LGC_KHZ_2048 15'h0800
`define LGC_KHZ_1544 15'h0608
`define LGC_KHZ_4096 15'h1000
`define LGC_KHZ_3088 15'h0C10
`define LGC_KHZ_8192 15'h2000
`define LGC_KHZ_6176 15'h1820
`define LGC_KHZ_16384 15'h4000
`define LGC_KHZ_12352 15'h3040
`define LGC_KHZ_NONE 15'h0000

// ==========================================================
// Loss of signal zero counts
`define LGC_LOS_ZEROS_STD 13'h00AF
`define LGC_LOS_ZEROS_EXT 13'h1000
`define LGC_CNT_W 13

`endif

// [lgc_props.sv]
/*
 Checker for the global line control block.
 Assumes it is bound to lgc_global_control and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
`include "lgc_map.vh"
// ==========================================================
// Port checker
module lgc_props
(
    // Clock and reset
    input wire clock,
    input wire reset_n,
    // Bus
    input wire [13:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_readdata,
    input wire avs_waitrequest,
    // Lines
    input wire [7:0] rx_data,
    input wire [7:0] rx_valid,
    input wire [7:0] line_out_in,
    input wire [7:0] line_out,
    input wire [7:0] line_out_oe,
    input wire [7:0] receive_loss_of_signal,
    input wire [3:0] master_clock_rate_select,
    input wire [14:0] master_clock_khz,
    input wire master_clock_reserved,
    input wire irq
);
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);
    answer_next_a: assert property ((avs_read || avs_write) &&
        avs_waitrequest |=> !avs_waitrequest) else $error("no answer");
    answer_once_a: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("answer too long");
    upper_zero_a: assert property (!avs_waitrequest |->
        avs_readdata[31:8] == 24'h000000) else $error("upper bits set");
    summary_rsvd_a: assert property (avs_read && avs_waitrequest &&
        avs_address[13:2] == `LGC_IDX_INT_SUM |=> avs_readdata[7:1] == 7'h00)
        else $error("summary reserved bits set");
    oe_uniform_a: assert property (line_out_oe == 8'h00 ||
        line_out_oe == 8'hFF) else $error("partial tristate");
    line_copy_a: assert property (reset_n |=>
        line_out == $past(line_out_in)) else $error("line copy wrong");
    rate_reserved_a: assert property (master_clock_reserved ==
        (master_clock_rate_select inside {[4'h2:4'h7]}))
        else $error("reserved flag wrong");
    rate_none_a: assert property (master_clock_reserved |->
        master_clock_khz == `LGC_KHZ_NONE) else $error("rate not zero");
    loss_clear_a: assert property (rx_valid[0] && rx_data[0] |=>
        !receive_loss_of_signal[0]) else $error("loss kept after one");
    loss_cause_a: assert property (
        $rose(receive_loss_of_signal[0]) |->
        $past(rx_valid[0]) && !$past(rx_data[0])) else $error("loss no zero");
    cover property ($rose(receive_loss_of_signal[0]));
    cover property ($rose(irq));
    cover property (!avs_waitrequest && avs_readdata[0]);
endmodule

bind lgc_global_control lgc_props u_props (.clock, .reset_n, .avs_address,
    .avs_read, .avs_write, .avs_readdata, .avs_waitrequest, .rx_data,
    .rx_valid, .line_out_in, .line_out, .line_out_oe, .receive_loss_of_signal,
    .master_clock_rate_select, .master_clock_khz, .master_clock_reserved,
    .irq);
`default_nettype wire

// [tb_top.sv]
/*
 Self-checking bench of the global line control block.
 Assumes the bus answers within the run's cycle ceiling.
*/
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Bench
module tb_top;
    logic clock = 1'b0, reset_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
    logic channel0_event = 1'b0;
    logic [3:0] avs_byteenable = 4'hF;
    logic [13:0] avs_address = 14'h0000;
    logic [31:0] avs_writedata = 32'h00000000;
    logic [7:0] rx_data = 8'h00, rx_valid = 8'h00, line_out_in = 8'hA5, q;
    wire [31:0] avs_readdata;
    wire avs_waitrequest, master_clock_reserved, irq;
    wire [7:0] line_out, line_out_oe, receive_loss_of_signal;
    wire [3:0] master_clock_rate_select;
    wire [14:0] master_clock_khz;
    int error_cnt = 0, num_checks = 0, cyc = 0;
    logic [11:0] ri [5] = '{12'hFE1, 12'hFE2, 12'hFE4, 12'hFE9, 12'hFEA};
    logic [7:0] rv [5] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h00};
    lgc_global_control u_dut (.clock, .reset_n, .avs_address, .avs_read,
        .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
        .avs_waitrequest, .rx_data, .rx_valid, .channel0_event, .line_out_in,
        .line_out, .line_out_oe, .receive_loss_of_signal,
        .master_clock_rate_select, .master_clock_khz, .master_clock_reserved,
        .irq);
    always #5 clock = ~clock;
    // Hang guard, well above the longest zero run
    always @(posedge clock)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            error_cnt++;
            results();
        end
    end
    task automatic chk(input string n, input logic [15:0] e, g);
        num_checks++;
        if (g !== e)
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        if (g !== e)
            error_cnt++;
    endtask
    task automatic acc(input logic w, input logic [11:0] i, logic [7:0] d);
        avs_address <= {i, 2'b00};
        avs_write <= w;
        avs_read <= ~w;
        avs_writedata <= {24'h000000, d};
        do @(posedge clock); while (avs_waitrequest !== 1'b0);
        q = avs_readdata[7:0];
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clock);
    endtask
    task automatic rd(input logic [11:0] i, input logic [7:0] e);
        acc(1'b0, i, 8'h00);
        chk("readdata", {8'h00, e}, {8'h00, q});
    endtask
    task automatic feed(input int n, input logic [7:0] d);
        repeat (n)
        begin
            rx_valid <= 8'hFF;
            rx_data <= d;
            @(posedge clock);
        end
        rx_valid <= 8'h00;
        @(posedge clock);
    endtask
    function automatic logic [15:0] khz(input logic [3:0] s);
        case (s)
            4'h0, 4'hE: khz = 16'h0800;
            4'h1, 4'hF: khz = 16'h0608;
            4'h8: khz = 16'h1000;
            4'h9: khz = 16'h0C10;
            4'hA: khz = 16'h2000;
            4'hB: khz = 16'h1820;
            4'hC: khz = 16'h4000;
            4'hD: khz = 16'h3040;
            default: khz = 16'h0000;
        endcase
    endfunction
    task results;
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial
    begin
        repeat (5) @(posedge clock);
        reset_n <= 1'b1;
        chk("oe", 16'h0000, {8'h00, line_out_oe});
        for (int k = 0; k < 5; k++) rd(ri[k], rv[k]);
        rd(12'h010, 8'h00);
        chk("line_out", 16'h00A5, {8'h00, line_out});
        for (int c = 0; c < 16; c++)
        begin
            acc(1'b1, 12'hFE9, {4'hA, c[3:0]});
            rd(12'hFE9, {4'h0, c[3:0]});
            chk("khz", khz(c[3:0]), {1'b0, master_clock_khz});
            chk("sel", {12'h000, c[3:0]},
                {12'h000, master_clock_rate_select});
            chk("rsvd", {15'h0000, c > 1 && c < 8}, {15'h0000,
                master_clock_reserved});
        end
        acc(1'b1, 12'hFE2, 8'h7F);
        avs_byteenable <= 4'hE;
        acc(1'b1, 12'hFE2, 8'h00);
        avs_byteenable <= 4'hF;
        rd(12'hFE2, 8'h7F);
        acc(1'b1, 12'hFE4, 8'hFF);
        chk("khz", 16'h0608, {1'b0, master_clock_khz});
        acc(1'b1, 12'hFE1, 8'h01);
        chk("oe", 16'h0000, {8'h00, line_out_oe});
        line_out_in <= 8'h3C;
        acc(1'b1, 12'hFE1, 8'h00);
        chk("oe", 16'h00FF, {8'h00, line_out_oe});
        chk("line_out", 16'h003C, {8'h00, line_out});
        acc(1'b0, 12'hFF9, 8'h00);
        feed(174, 8'h00);
        chk("loss", 16'h0000, {8'h00, receive_loss_of_signal});
        feed(1, 8'h00);
        chk("loss", 16'h00FF, {8'h00, receive_loss_of_signal});
        feed(100, 8'h00);
        feed(1, 8'h01);
        feed(100, 8'h00);
        chk("loss", 16'h00FE, {8'h00, receive_loss_of_signal});
        rd(12'hFF9, 8'h02);
        acc(1'b1, 12'hFE1, 8'h02);
        feed(1, 8'hFF);
        feed(4095, 8'h00);
        chk("loss", 16'h0000, {8'h00, receive_loss_of_signal});
        feed(1, 8'h00);
        chk("loss", 16'h00FF, {8'h00, receive_loss_of_signal});
        acc(1'b0, 12'hFF9, 8'h00);
        channel0_event <= 1'b1;
        @(posedge clock);
        channel0_event <= 1'b0;
        @(posedge clock);
        chk("irq", 16'h0000, {15'h0000, irq});
        acc(1'b1, 12'hFFA, 8'h01);
        chk("irq", 16'h0001, {15'h0000, irq});
        rd(12'hFEA, 8'h01);
        rd(12'hFEA, 8'h00);
        rd(12'hFF9, 8'h01);
        chk("irq", 16'h0000, {15'h0000, irq});
        results();
    end
endmodule
`default_nettype wire
